/* core/timer16_wave_pkg.sv */
package timer16_wave_pkg;
    localparam int CountWidth = 16;
    localparam int ModeWidth = 4;
    localparam int ActionWidth = 2;
    localparam logic [15:0] CountZero = 16'h0000;
    localparam logic [15:0] CountMax = 16'hffff;
    localparam logic [15:0] CountOne = 16'h0001;
    localparam logic [15:0] Top8 = 16'h00ff;
    localparam logic [15:0] Top9 = 16'h01ff;
    localparam logic [15:0] Top10 = 16'h03ff;
    localparam logic [3:0] ModeClearA = 4'h4;
    localparam logic [3:0] ModeFast8 = 4'h5;
    localparam logic [3:0] ModeFast9 = 4'h6;
    localparam logic [3:0] ModeFast10 = 4'h7;
    localparam logic [3:0] ModeClearCapture = 4'hc;
    localparam logic [3:0] ModeFastCapture = 4'he;
    localparam logic [3:0] ModeFastA = 4'hf;
    localparam logic [1:0] ActionNone = 2'h0;
    localparam logic [1:0] ActionToggle = 2'h1;
    localparam logic [1:0] ActionClear = 2'h2;
    localparam logic [1:0] ActionSet = 2'h3;

    typedef enum logic [1:0]
    {
        FamilyOther = 2'b00,
        FamilyClear = 2'b01,
        FamilyFast = 2'b11
    } family_t;

    typedef enum logic [1:0]
    {
        TopFixed = 2'b00,
        TopCompareA = 2'b01,
        TopCapture = 2'b11
    } top_source_t;
endpackage

/* core/timer16_ctc_fast_pwm.sv */
`timescale 1ns/1ps
// Operation
// - modes 4 and 12 clear the count on match with compare A or capture register.
// - clear-on-match sets the flag of the TOP register when count reaches TOP on a tick not blocked by a count write.
// - clear-on-match TOP writes act at once; below count it wraps via 0xffff.
// - action 1 in clear-on-match toggles wave output A on each compare match.
// - wave output A drives the pin only while its direction bit is one.
// - toggle period is two times one plus compare A timer ticks.
// - clear-on-match sets overflow flag when count rolls from max to zero.
// - modes 5, 6, 7, 14, 15 count up from bottom to TOP, then restart.
// - fast TOP is 0xff, 0x1ff, 0x3ff, capture, or compare A; clear next tick.
// - fast action 2 clears on match, sets at bottom; action 3 the reverse.
// - a channel's match flag sets when count equals its compare value on a tick not blocked by a count write.
// - fast mode sets overflow at TOP, plus the TOP register's flag likewise.
// - fixed TOP masks compare bits above its width on every compare write.
// - capture register is unbuffered in fast mode; low writes wrap via max.
// - fast mode buffers compare A writes, loading them when count hits TOP.
// - compare zero gives one-tick spikes; compare at TOP gives a steady level.
// - fast actions 2 and 3 give an output period of TOP plus one timer ticks; action 1 gives twice that.
// - fast action 1 toggles output A on match, using buffered compare A.
// - action zero leaves the wave output state unchanged on matches.
// - any nonzero action replaces the port output value with the wave state.
// - a count write blocks compare matches in the next timer tick.
module timer16_ctc_fast_pwm
    import timer16_wave_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEnable,
    input wire logic timerTick,
    input wire logic [ModeWidth-1:0] waveformModeSelect,
    input wire logic [ActionWidth-1:0] outputActionSelectA,
    input wire logic [ActionWidth-1:0] outputActionSelectB,
    input wire logic countWrite,
    input wire logic [CountWidth-1:0] countWriteData,
    input wire logic compareAWrite,
    input wire logic compareBWrite,
    input wire logic [CountWidth-1:0] compareWriteData,
    input wire logic captureWrite,
    input wire logic [CountWidth-1:0] captureWriteData,
    input wire logic pinDirectionA,
    input wire logic pinDirectionB,
    input wire logic portValueA,
    input wire logic portValueB,
    output logic [CountWidth-1:0] countValue,
    output logic [CountWidth-1:0] compareAValue,
    output logic [CountWidth-1:0] compareBValue,
    output logic [CountWidth-1:0] captureTopValue,
    output logic overflowEvent,
    output logic compareAMatchEvent,
    output logic compareBMatchEvent,
    output logic captureEvent,
    output logic waveOutA,
    output logic waveOutB,
    output logic pinOutA,
    output logic pinOutB,
    output logic pinOutEnableALow,
    output logic pinOutEnableBLow,
    output logic blockActive
);
    import timer16_wave_pkg::*;

    // all state in one register so the enable freezes it in one place
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cmpA;
        logic [15:0] cmpABuf;
        logic [15:0] cmpB;
        logic [15:0] capture;
        logic blockMatch;
        logic ovf;
        logic matchA;
        logic matchB;
        logic capFlag;
        logic waveA;
        logic waveB;
    } state_t;

    state_t s_q;
    state_t s_d;

    // mode decode; unknown encodings fall to the other family
    function automatic family_t familyOf(input logic [3:0] mode);
        if (mode == ModeClearA || mode == ModeClearCapture)
            return FamilyClear;
        else if (mode == ModeFast8 || mode == ModeFast9
                 || mode == ModeFast10 || mode == ModeFastCapture
                 || mode == ModeFastA)
            return FamilyFast;
        else
            return FamilyOther;
    endfunction

    // which register, if any, defines TOP
    function automatic top_source_t topSourceOf(input logic [3:0] mode);
        if (mode == ModeClearA || mode == ModeFastA)
            return TopCompareA;
        else if (mode == ModeClearCapture || mode == ModeFastCapture)
            return TopCapture;
        else
            return TopFixed;
    endfunction

    // fixed TOP of the 8, 9 and 10 bit fast modes
    function automatic logic [15:0] fixedTopOf(input logic [3:0] mode);
        if (mode == ModeFast8)
            return Top8;
        else if (mode == ModeFast9)
            return Top9;
        else if (mode == ModeFast10)
            return Top10;
        else
            return CountMax;
    endfunction

    // equality is ignored for one tick after a count write
    function automatic logic matchOf(input logic [15:0] cnt,
                                     input logic [15:0] cmp,
                                     input logic blocked);
        return (cnt == cmp) && !blocked;
    endfunction

    function automatic logic [15:0] topOf(input top_source_t src,
                                          input logic [15:0] cmpA,
                                          input logic [15:0] cap,
                                          input logic [15:0] fixedTop);
        if (src == TopCompareA)
            return cmpA;
        else if (src == TopCapture)
            return cap;
        else
            return fixedTop;
    endfunction

    // fixed TOP modes drop compare bits above the TOP width on every write
    function automatic logic [15:0] maskCompare(input logic [15:0] data,
                                                input family_t fam,
                                                input top_source_t src,
                                                input logic [15:0] top);
        if (fam == FamilyFast && src == TopFixed)
            return data & top;
        else
            return data;
    endfunction

    // clear-on-match action for one channel at a compare match
    function automatic logic clearWave(input logic cur,
                                       input logic [1:0] act,
                                       input logic match);
        logic r;
        r = cur;
        if (match)
        begin
            if (act == ActionToggle)
                r = ~cur;
            else if (act == ActionClear)
                r = 1'b0;
            else if (act == ActionSet)
                r = 1'b1;
        end
        return r;
    endfunction

    // a nonzero action hands the pin to the wave state; direction stays apart
    function automatic logic pinSource(input logic [1:0] act,
                                       input logic wave,
                                       input logic port);
        if (act != ActionNone)
            return wave;
        else
            return port;
    endfunction

    // fast-mode waveform action for one channel at match or at bottom
    function automatic logic fastWave(input logic cur,
                                      input logic [1:0] act,
                                      input logic match,
                                      input logic bottom,
                                      input logic toggleOk);
        logic r;
        r = cur;
        if (act == ActionToggle && toggleOk && match)
            r = ~cur;
        else if (act == ActionClear)
        begin
            if (match)
                r = 1'b0;
            else if (bottom)
                r = 1'b1;
        end
        else if (act == ActionSet)
        begin
            if (match)
                r = 1'b1;
            else if (bottom)
                r = 1'b0;
        end
        return r;
    endfunction

    family_t family;
    top_source_t topSrc;
    logic [15:0] topValue;
    logic [15:0] fixedTop;
    logic atTop;
    logic hitA;
    logic hitB;
    logic atMax;
    logic capHit;
    logic tickLive;

    // decode of the mode and the compare results of the present count
    always_comb
    begin
        family = familyOf(waveformModeSelect);
        topSrc = topSourceOf(waveformModeSelect);
        fixedTop = fixedTopOf(waveformModeSelect);
        // register TOP is read live, so a low write is passed until the wrap
        topValue = topOf(topSrc, s_q.cmpA, s_q.capture,
                         fixedTop);
        atTop = (s_q.count == topValue);
        atMax = (s_q.count == CountMax);
        // a count write blocks matches on the following tick
        hitA = matchOf(s_q.count, s_q.cmpA, s_q.blockMatch);
        hitB = matchOf(s_q.count, s_q.cmpB, s_q.blockMatch);
        // the capture TOP flag is blocked like a compare match
        capHit = (topSrc == TopCapture) && atTop && !s_q.blockMatch;
        // other modes belong to other logic and ignore the timer tick
        tickLive = timerTick && (family != FamilyOther);
    end

    always_comb
    begin
        logic topEvent;
        logic [15:0] maskedCmp;
        topEvent = 1'b0;
        maskedCmp = maskCompare(compareWriteData, family, topSrc,
                                fixedTop);
        s_d = s_q;

        // event strobes last one cycle; sticky flags live with the registers
        s_d.ovf = 1'b0;
        s_d.matchA = 1'b0;
        s_d.matchB = 1'b0;
        s_d.capFlag = 1'b0;

        if (tickLive)
        begin
            s_d.blockMatch = 1'b0;
            // a blocked tick also skips the clear when compare A is TOP
            topEvent = atTop && !(topSrc == TopCompareA && s_q.blockMatch);
            if (capHit)
                s_d.capFlag = 1'b1;
            s_d.matchA = hitA;
            s_d.matchB = hitB;
            if (family == FamilyClear)
            begin
                // TOP is live: a value below count is passed and wraps
                if (topEvent)
                    s_d.count = CountZero;
                else
                    s_d.count = s_q.count + CountOne;
                // overflow marks the roll from max, not the clear at TOP
                s_d.ovf = atMax;
                s_d.waveA = clearWave(s_q.waveA, outputActionSelectA,
                                      hitA);
                s_d.waveB = clearWave(s_q.waveB, outputActionSelectB,
                                      hitB);
            end
            else
            begin
                // compare A takes its buffered value at TOP, with the clear
                if (topEvent)
                begin
                    s_d.count = CountZero;
                    s_d.ovf = 1'b1;
                    s_d.cmpA = s_q.cmpABuf;
                end
                else
                begin
                    s_d.count = s_q.count + CountOne;
                end
                // match wins over bottom so compare at TOP gives a steady level
                s_d.waveA = fastWave(s_q.waveA, outputActionSelectA, hitA,
                                     topEvent, 1'b1);
                // channel B has no toggle action in fast mode
                s_d.waveB = fastWave(s_q.waveB, outputActionSelectB, hitB,
                                     topEvent, 1'b0);
            end
        end

        // writes come last so a same-cycle write beats the tick
        if (countWrite)
        begin
            s_d.count = countWriteData;
            s_d.blockMatch = 1'b1;
        end
        if (compareAWrite)
        begin
            s_d.cmpABuf = maskedCmp;
            if (family != FamilyFast)
                s_d.cmpA = maskedCmp;
        end
        if (compareBWrite)
        begin
            s_d.cmpB = maskedCmp;
        end
        if (captureWrite)
        begin
            s_d.capture = captureWriteData;
        end
    end

    // a low enable freezes every bit of state, strobes included
    always_ff @(posedge clk)
    begin
        if (rst)
            s_q <= '0;
        else if (clkEnable)
            s_q <= s_d;
        else
            s_q <= s_q;
    end

    always_comb
    begin
        countValue = s_q.count;
        compareAValue = s_q.cmpA;
        compareBValue = s_q.cmpB;
        captureTopValue = s_q.capture;
        overflowEvent = s_q.ovf;
        compareAMatchEvent = s_q.matchA;
        compareBMatchEvent = s_q.matchB;
        captureEvent = s_q.capFlag;
        waveOutA = s_q.waveA;
        waveOutB = s_q.waveB;
        blockActive = (family != FamilyOther);
        pinOutA = pinSource(outputActionSelectA, s_q.waveA, portValueA);
        pinOutB = pinSource(outputActionSelectB, s_q.waveB, portValueB);
        // enable is low while the pin is driven
        pinOutEnableALow = ~pinDirectionA;
        pinOutEnableBLow = ~pinDirectionB;
    end
endmodule // timer16_ctc_fast_pwm

/* test/timer16_ctc_fast_pwm_monitor.sv */
`timescale 1ns/1ps
module timer16_ctc_fast_pwm_monitor
    import timer16_wave_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEnable,
    input wire logic timerTick,
    input wire logic [ModeWidth-1:0] waveformModeSelect,
    input wire logic [ActionWidth-1:0] outputActionSelectA,
    input wire logic countWrite,
    input wire logic pinDirectionA,
    input wire logic portValueA,
    input wire logic [CountWidth-1:0] countValue,
    input wire logic [CountWidth-1:0] compareAValue,
    input wire logic overflowEvent,
    input wire logic compareAMatchEvent,
    input wire logic waveOutA,
    input wire logic pinOutA,
    input wire logic pinOutEnableALow,
    input wire logic blockActive
);
    logic blocked_q, tk, hitA, m4, m5;
    assign tk = clkEnable && timerTick && !countWrite;
    assign hitA = tk && !blocked_q && countValue == compareAValue;
    assign m4 = waveformModeSelect == ModeClearA;
    assign m5 = waveformModeSelect == ModeFast8;
    // a count write masks matches up to and including the next tick
    always_ff @(posedge clk)
        blocked_q <= rst ? 1'b0 : !clkEnable ? blocked_q :
            countWrite || (blocked_q && !timerTick);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence ctcHit;
        m4 && hitA;
    endsequence
    sequence ctcCleared;
        countValue == CountZero && compareAMatchEvent;
    endsequence
    chk_ctc_clear: assert property (ctcHit |=> ctcCleared)
        else $error("ctc match did not clear");
    chk_ctc_toggle: assert property (ctcHit and
        (outputActionSelectA == ActionToggle) |=> waveOutA != $past(waveOutA))
        else $error("ctc toggle missing");
    chk_pin_enable: assert property (pinOutEnableALow == !pinDirectionA)
        else $error("pin enable wrong");
    chk_pin_source: assert property (pinOutA ==
        (outputActionSelectA != ActionNone ? waveOutA : portValueA))
        else $error("pin source wrong");
    chk_ctc_overflow: assert property (m4 && tk && countValue ==
        CountMax && compareAValue != CountMax |=> overflowEvent)
        else $error("ctc overflow missing");
    chk_fast_top: assert property (m5 && tk && countValue == Top8
        |=> overflowEvent && countValue == CountZero)
        else $error("fast top wrong");
    chk_fast_bottom: assert property (m5 && tk && countValue == Top8 &&
        compareAValue != Top8 && outputActionSelectA == ActionClear
        |=> waveOutA) else $error("fast bottom set missing");
    chk_fast_match: assert property (m5 && hitA &&
        outputActionSelectA == ActionSet |=> waveOutA && compareAMatchEvent)
        else $error("fast match wrong");
    chk_tick_hold: assert property (!clkEnable |=>
        $stable(countValue) && $stable(waveOutA))
        else $error("state moved while disabled");
    chk_idle_mode: assert property (!blockActive && !countWrite
        |=> $stable(countValue)) else $error("idle mode counted");
endmodule // timer16_ctc_fast_pwm_monitor

bind timer16_ctc_fast_pwm timer16_ctc_fast_pwm_monitor
    u_timer16_ctc_fast_pwm_monitor (.*);

/* test/test_timer16_ctc_fast_pwm.sv */
`timescale 1ns/1ps
module test_timer16_ctc_fast_pwm;
    import timer16_wave_pkg::*;
    logic clk = 1'b0, rst = 1'b1, clkEnable = 1'b1, timerTick = 1'b0;
    logic [ModeWidth-1:0] waveformModeSelect = ModeClearA;
    logic [ActionWidth-1:0] outputActionSelectA = 2'h0;
    logic [ActionWidth-1:0] outputActionSelectB = 2'h0;
    logic countWrite = 1'b0, compareAWrite = 1'b0, compareBWrite = 1'b0;
    logic captureWrite = 1'b0, pinDirectionA = 1'b1, pinDirectionB = 1'b0;
    logic portValueA = 1'b1, portValueB = 1'b0;
    logic [CountWidth-1:0] countWriteData = 16'h0000;
    logic [CountWidth-1:0] compareWriteData = 16'h0000;
    logic [CountWidth-1:0] captureWriteData = 16'h0000;
    logic [CountWidth-1:0] countValue, compareAValue, compareBValue;
    logic [CountWidth-1:0] captureTopValue, held;
    logic overflowEvent, compareAMatchEvent, compareBMatchEvent;
    logic captureEvent, waveOutA, waveOutB, pinOutA, pinOutB;
    logic pinOutEnableALow, pinOutEnableBLow, blockActive;
    int err_count = 0, checks_done = 0, hi, per, n;
    int cs[3] = '{0, 2, 5};
    int ft[3] = '{255, 511, 1023};
    logic [3:0] fm[3] = '{ModeFast8, ModeFast9, ModeFast10};

    timer16_ctc_fast_pwm u_timer16_ctc_fast_pwm (.*);

    initial
    begin
        forever #2 clk = ~clk;
    end

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic setc(logic [3:0] m, logic [1:0] a, logic t);
        @(negedge clk);
        waveformModeSelect = m;
        outputActionSelectA = a;
        timerTick = t;
    endtask

    // 0 count, 1 compare A, 2 capture, 3 compare B; one strobe per write
    task automatic wr(int s, logic [15:0] d);
        @(negedge clk);
        countWriteData = d;
        compareWriteData = d;
        captureWriteData = d;
        countWrite = (s == 0);
        compareAWrite = (s == 1);
        captureWrite = (s == 2);
        compareBWrite = (s == 3);
        @(negedge clk);
        {countWrite, compareAWrite, compareBWrite, captureWrite} = 4'b0000;
    endtask

    task automatic waitEv(int s, output int c);
        c = 0;
        do
        begin
            step();
            c++;
        end
        while (!(s == 0 ? overflowEvent : s == 1 ? compareAMatchEvent :
            s == 2 ? captureEvent : compareBMatchEvent) && c < 3000);
    endtask

    // one rise of wave A to the next, counted in samples
    task automatic measure(output int h, output int p);
        logic prev;
        int k;
        prev = 1'b1;
        k = 0;
        h = 0;
        p = 0;
        while (!(waveOutA === 1'b1 && prev === 1'b0) && k < 3000)
        begin
            prev = waveOutA;
            step();
            k++;
        end
        do
        begin
            p++;
            h += (waveOutA === 1'b1);
            prev = waveOutA;
            step();
            k++;
        end
        while (!(waveOutA === 1'b1 && prev === 1'b0) && k < 6000);
    endtask

    task automatic run(int eh, int ep);
        measure(hi, per);
        measure(hi, per);
        chk("high time", hi[15:0], eh[15:0]);
        chk("period", per[15:0], ep[15:0]);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk("count", countValue, 16'h0000);
        chk("wave", 16'(waveOutA), 16'h0000);
        foreach (cs[i])
        begin
            setc(ModeClearA, ActionToggle, 1'b0);
            wr(1, cs[i][15:0]);
            // the blocked first tick rolls max to zero, so zero still matches
            wr(0, 16'hffff);
            setc(ModeClearA, ActionToggle, 1'b1);
            run(cs[i] + 1, 2 * cs[i] + 2);
            chk("pin", 16'(pinOutA), 16'(waveOutA));
            chk("enable", 16'(pinOutEnableALow), 16'h0000);
        end
        setc(ModeClearA, ActionNone, 1'b1);
        held = 16'(waveOutA);
        repeat (20) step();
        chk("wave held", 16'(waveOutA), held);
        chk("port", 16'(pinOutA), 16'h0001);
        chk("pin b", 16'(pinOutB), 16'(portValueB));
        chk("enable b", 16'(pinOutEnableBLow), 16'h0001);
        chk("wave b", 16'(waveOutB), 16'h0000);
        @(negedge clk);
        pinDirectionA = 1'b0;
        #1;
        chk("enable", 16'(pinOutEnableALow), 16'h0001);
        @(negedge clk);
        pinDirectionA = 1'b1;
        $display("clear-on-match output done");
        for (int m = 0; m < 2; m++)
        begin
            setc(m ? ModeClearCapture : ModeClearA, ActionNone, 1'b0);
            wr(0, 16'hfff0);
            wr(m + 1, 16'h0003);
            timerTick = 1'b1;
            waitEv(0, n);
            chk("wrap ticks", n[15:0], 16'h0010);
            waitEv(m + 1, n);
            chk("top ticks", n[15:0], 16'h0004);
            chk("cleared", countValue, 16'h0000);
        end
        setc(ModeClearA, ActionNone, 1'b0);
        wr(1, 16'h0007);
        wr(0, 16'h0007);
        timerTick = 1'b1;
        @(negedge clk);
        timerTick = 1'b0;
        chk("blocked count", countValue, 16'h0008);
        chk("blocked match", 16'(compareAMatchEvent), 16'h0000);
        $display("clear-on-match wrap done");
        foreach (fm[i])
        begin
            setc(fm[i], ActionClear, 1'b0);
            wr(1, 16'h0040);
            setc(fm[i], ActionClear, 1'b1);
            run(65, ft[i] + 1);
        end
        setc(ModeFast8, ActionSet, 1'b1);
        run(191, 256);
        setc(ModeFast8, ActionClear, 1'b0);
        wr(1, 16'h0000);
        setc(ModeFast8, ActionClear, 1'b1);
        run(1, 256);
        setc(ModeFast8, ActionClear, 1'b0);
        wr(1, 16'h1230);
        chk("active", compareAValue, 16'h0000);
        timerTick = 1'b1;
        waitEv(0, n);
        chk("loaded", compareAValue, 16'h0030);
        wr(3, 16'h1250);
        chk("compare b", compareBValue, 16'h0050);
        waitEv(3, n);
        chk("b match count", countValue, 16'h0051);
        setc(ModeFastCapture, ActionClear, 1'b0);
        wr(0, 16'h0000);
        wr(2, 16'h0020);
        chk("capture reg", captureTopValue, 16'h0020);
        wr(1, 16'h0010);
        timerTick = 1'b1;
        run(17, 33);
        waitEv(0, n);
        chk("capture", 16'(captureEvent), 16'h0001);
        setc(ModeFastCapture, ActionClear, 1'b0);
        wr(0, 16'hfff0);
        timerTick = 1'b1;
        waitEv(2, n);
        chk("missed top", n[15:0], 16'h0031);
        setc(ModeFastA, ActionToggle, 1'b0);
        wr(0, 16'h0000);
        wr(1, 16'h0005);
        timerTick = 1'b1;
        run(6, 12);
        $display("fast pwm done");
        @(negedge clk);
        clkEnable = 1'b0;
        held = countValue;
        repeat (5) step();
        chk("frozen", countValue, held);
        @(negedge clk);
        clkEnable = 1'b1;
        setc(4'h0, ActionNone, 1'b1);
        step();
        held = countValue;
        repeat (5) step();
        chk("idle", countValue, held);
        chk("inactive", 16'(blockActive), 16'h0000);
        $display("hold and idle done");
        tally_and_finish();
    end
endmodule // test_timer16_ctc_fast_pwm
